/* File: design/bmd_params.svh */
// constants for the bit manipulation datapath
`ifndef BMD_PARAMS_SVH
`define BMD_PARAMS_SVH
`define BMD_BYTE_W 8
`define BMD_BITNO_W 3
`define BMD_BYTE_ZERO 8'h00
`define BMD_BYTE_ONES 8'hff
`define BMD_FLAG_RST 1'b0
`endif

/* File: design/bmd_pkg.sv */
// types for the bit manipulation datapath
package bmd_pkg;
  typedef enum logic [3:0] {
    BMD_OP_NONE = 4'h0,
    BMD_OP_CARRY_OR_INV = 4'h1,
    BMD_OP_CARRY_XOR = 4'h2,
    BMD_OP_CARRY_XOR_INV = 4'h3,
    BMD_OP_LOAD_BIT = 4'h4,
    BMD_OP_LOAD_INV_BIT = 4'h5,
    BMD_OP_STORE_CARRY = 4'h6,
    BMD_OP_STORE_INV_CARRY = 4'h7,
    BMD_OP_STORE_ZERO = 4'h8,
    BMD_OP_STORE_INV_ZERO = 4'h9,
    BMD_OP_EXTRACT_FIELD = 4'ha,
    BMD_OP_INSERT_FIELD = 4'hb
  } bmd_op_t;
endpackage : bmd_pkg

/* File: design/bmd_field_unit.sv */
// combinational bit-field extract and insert on one byte
`timescale 1ns/1ps
`include "bmd_params.svh"
module bmd_field_unit #(
  parameter int W = `BMD_BYTE_W
) (
  // operands
  input wire logic [W-1:0] mem_byte,
  input wire logic [W-1:0] field_mask,
  input wire logic [W-1:0] reg_low,
  // results
  output logic [W-1:0] extracted,
  output logic [W-1:0] inserted
);
  logic [W-1:0] lowest;
  logic [W-1:0] masked;
  logic [W-1:0] shifted;

  // shift right until the mask's lowest set bit sits at bit zero
  always_comb begin
    lowest = field_mask & (~field_mask + 1'b1);
    masked = mem_byte & field_mask;
    extracted = `BMD_BYTE_ZERO;
    shifted = `BMD_BYTE_ZERO;
    for (int i = 0; i < W; i++) begin
      if (lowest[i]) begin
        extracted = masked >> i;
        shifted = reg_low << i;
      end
    end
    inserted = (mem_byte & ~field_mask) | (shifted & field_mask);
  end
endmodule : bmd_field_unit

/* File: design/bmd_datapath.sv */
// bit manipulation datapath: carry logic, bit stores, field moves
// Functional notes
// - bit position comes from a 3-bit immediate field
// - inverted-or: carry becomes carry or not bit
// - xor: carry becomes carry xor bit
// - inverted xor: carry becomes carry xor not bit
// - bit load copies selected bit into carry
// - inverted bit load writes not bit into carry
// - carry store writes carry into bit, others kept
// - inverted carry store writes not carry into bit
// - zero flag store writes zero flag into memory bit only
// - inverted zero flag store writes not zero flag, memory only
// - field extract moves memory field to register low bits
// - field insert moves register low bits into memory field
`timescale 1ns/1ps
`include "bmd_params.svh"
module bmd_datapath #(
  // operand byte width; the bit number only reaches the low eight bits
  parameter int W = `BMD_BYTE_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // request from the decoder
  input wire logic op_valid,
  input wire bmd_pkg::bmd_op_t op,
  input wire logic [`BMD_BITNO_W-1:0] bit_imm,
  input wire logic [W-1:0] field_mask,
  input wire logic operand_is_mem,
  input wire logic [W-1:0] source_operand,
  input wire logic [W-1:0] source_register,
  // flags in
  input wire logic carry_in,
  input wire logic zero_in,
  // results
  output logic done,
  output logic carry_we,
  output logic carry_out,
  output logic byte_we,
  output logic byte_to_mem,
  output logic [W-1:0] byte_out,
  output logic reg_we,
  output logic [W-1:0] reg_out,
  output logic illegal
);
  // next values of the strobe flops
  logic next_done;
  logic next_carry_we;
  logic next_byte_we;
  logic next_reg_we;
  logic next_illegal;
  // next values of the data flops
  logic next_carry_out;
  logic next_byte_to_mem;
  logic [W-1:0] next_byte_out;
  logic [W-1:0] next_reg_out;
  // operand bit picked by the immediate bit number
  logic sel_bit;
  logic [W-1:0] bit_hot;
  // field unit results, both computed every cycle
  logic [W-1:0] extracted;
  logic [W-1:0] inserted;

  // replace one bit of a byte, leaving the others alone
  // the bit number is three bits wide, so it never indexes past bit 7
  function automatic logic [W-1:0] put_bit(
      input logic [W-1:0] b,
      input logic [`BMD_BITNO_W-1:0] n,
      input logic v);
    logic [W-1:0] r;
    r = b;
    r[n] = v;
    return r;
  endfunction : put_bit

  // field unit is purely combinational; its results are registered below
  bmd_field_unit #(.W(W)) u_field (
    .mem_byte(source_operand),
    .field_mask(field_mask),
    .reg_low(source_register),
    .extracted(extracted),
    .inserted(inserted)
  );

  // one-hot decode of the bit number; an and-or tree per bit keeps the
  // select flat instead of a wide multiplexer
  for (genvar g = 0; g < W; g++) begin : g_bit_hot
    assign bit_hot[g] = (int'(bit_imm) == g);
  end
  assign sel_bit = |(source_operand & bit_hot);

  // next results; store ops rewrite the fetched byte in place
  // strobes fall back low every cycle, data keep their last value so a
  // write-back stage can still read them after the strobe has gone
  always_comb begin
    // defaults: nothing written this cycle
    next_done = op_valid;
    next_carry_we = 1'b0;
    next_carry_out = carry_out;
    next_byte_we = 1'b0;
    next_byte_to_mem = byte_to_mem;
    next_byte_out = byte_out;
    next_reg_we = 1'b0;
    next_reg_out = reg_out;
    next_illegal = 1'b0;
    if (op_valid) begin
      unique case (op)
        // carry or'ed with the inverted operand bit
        bmd_pkg::BMD_OP_CARRY_OR_INV: begin
          next_carry_we = 1'b1;
          next_carry_out = carry_in | ~sel_bit;
        end

        // carry xor'ed with the operand bit
        bmd_pkg::BMD_OP_CARRY_XOR: begin
          next_carry_we = 1'b1;
          next_carry_out = carry_in ^ sel_bit;
        end

        // carry xor'ed with the inverted operand bit
        bmd_pkg::BMD_OP_CARRY_XOR_INV: begin
          next_carry_we = 1'b1;
          next_carry_out = carry_in ^ ~sel_bit;
        end

        // plain load: the old carry is thrown away
        bmd_pkg::BMD_OP_LOAD_BIT: begin
          next_carry_we = 1'b1;
          next_carry_out = sel_bit;
        end

        // inverted load: the old carry is thrown away
        bmd_pkg::BMD_OP_LOAD_INV_BIT: begin
          next_carry_we = 1'b1;
          next_carry_out = ~sel_bit;
        end

        // carry into one bit; register or memory destination alike
        bmd_pkg::BMD_OP_STORE_CARRY: begin
          next_byte_we = 1'b1;
          next_byte_to_mem = operand_is_mem;
          next_byte_out = put_bit(source_operand, bit_imm, carry_in);
        end

        // inverted carry into one bit; the other seven are kept
        bmd_pkg::BMD_OP_STORE_INV_CARRY: begin
          next_byte_we = 1'b1;
          next_byte_to_mem = operand_is_mem;
          next_byte_out = put_bit(source_operand, bit_imm, ~carry_in);
        end

        // zero flag stores have a memory path only
        bmd_pkg::BMD_OP_STORE_ZERO,
        bmd_pkg::BMD_OP_STORE_INV_ZERO: begin
          // register destination is refused, nothing written
          if (operand_is_mem) begin
            next_byte_we = 1'b1;
            next_byte_to_mem = 1'b1;
            next_byte_out = put_bit(source_operand, bit_imm,
              (op == bmd_pkg::BMD_OP_STORE_ZERO) ? zero_in : ~zero_in);
          end else begin
            next_illegal = 1'b1;
          end
        end

        // field to register; upper bits come back zero from the unit
        bmd_pkg::BMD_OP_EXTRACT_FIELD: begin
          next_reg_we = 1'b1;
          next_reg_out = extracted;
        end

        // register low bits into the field, outer bits of the byte kept
        bmd_pkg::BMD_OP_INSERT_FIELD: begin
          next_byte_we = 1'b1;
          next_byte_to_mem = 1'b1;
          next_byte_out = inserted;
        end

        // no-op and spare codes: flag them so the decoder can trap
        default: begin
          next_illegal = 1'b1; // unused opcodes flagged, no write
        end
      endcase
    end
  end

  // strobe registers: each is high for exactly the result cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
      carry_we <= 1'b0;
      byte_we <= 1'b0;
      reg_we <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done <= next_done;
      carry_we <= next_carry_we;
      byte_we <= next_byte_we;
      reg_we <= next_reg_we;
      illegal <= next_illegal;
    end
  end

  // data registers; they hold their last value between ops, which costs
  // a feedback mux but lets the write-back stage sample late
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      carry_out <= `BMD_FLAG_RST;
      byte_to_mem <= 1'b0;
      byte_out <= `BMD_BYTE_ZERO;
      reg_out <= `BMD_BYTE_ZERO;
    end else begin
      carry_out <= next_carry_out;
      byte_to_mem <= next_byte_to_mem;
      byte_out <= next_byte_out;
      reg_out <= next_reg_out;
    end
  end
endmodule : bmd_datapath

/* File: verif/bmd_mem_model.sv */
// operand memory byte behind the datapath
`timescale 1ns/1ps
module bmd_mem_model (
  // clock, reset, preset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ld,
  input wire logic [7:0] ld_val,
  // write-back
  input wire logic byte_we,
  input wire logic byte_to_mem,
  input wire logic [7:0] byte_out,
  // fetched byte
  output logic [7:0] source_operand
);
  // register write-backs must never reach the memory byte
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) source_operand <= 8'h00;
    else if (ld) source_operand <= ld_val;
    else if (byte_we && byte_to_mem) source_operand <= byte_out;
endmodule : bmd_mem_model

/* File: verif/bmd_datapath_properties.sv */
// checker for the bit manipulation datapath
`timescale 1ns/1ps
module bmd_datapath_chk (
  // request
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic operand_is_mem,
  input wire logic carry_in,
  input wire logic zero_in,
  input wire bmd_pkg::bmd_op_t op,
  input wire logic [2:0] bit_imm,
  input wire logic [7:0] source_operand,
  // result
  input wire logic carry_we,
  input wire logic carry_out,
  input wire logic byte_we,
  input wire logic illegal,
  input wire logic [7:0] byte_out
);
  bmd_pkg::bmd_op_t hit;
  logic x, pc, pm;
  logic [7:0] e_c, e_iz;
  wire logic [7:0] m = 8'h01 << bit_imm;
  // launch-cycle view, so each check lands on the result cycle
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) hit <= bmd_pkg::BMD_OP_NONE;
    else hit <= op_valid ? op : bmd_pkg::BMD_OP_NONE;
  // data copies need no reset: hit gates every use
  always_ff @(posedge core_clk) begin
    x <= source_operand[bit_imm];
    pc <= carry_in;
    pm <= operand_is_mem;
    e_c <= carry_in ? source_operand | m : source_operand & ~m;
    e_iz <= zero_in ? source_operand & ~m : source_operand | m;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  or_inv_a: assert property (
    hit == bmd_pkg::BMD_OP_CARRY_OR_INV |-> carry_we && carry_out == (pc | !x))
    else $error("bad or");
  xor_carry_a: assert property (
    hit == bmd_pkg::BMD_OP_CARRY_XOR |-> carry_we && carry_out == (pc ^ x))
    else $error("bad xor");
  inv_xor_a: assert property (
    hit == bmd_pkg::BMD_OP_CARRY_XOR_INV |-> carry_we && carry_out != (pc ^ x))
    else $error("bad xor inv");
  load_bit_a: assert property (
    hit == bmd_pkg::BMD_OP_LOAD_BIT |-> carry_we && carry_out == x)
    else $error("bad load");
  inv_load_a: assert property (
    hit == bmd_pkg::BMD_OP_LOAD_INV_BIT |-> carry_we && carry_out != x)
    else $error("bad load inv");
  store_c_a: assert property (
    hit == bmd_pkg::BMD_OP_STORE_CARRY |-> byte_we && byte_out == e_c)
    else $error("bad store");
  inv_zst_a: assert property (pm &&
    hit == bmd_pkg::BMD_OP_STORE_INV_ZERO |-> byte_we && byte_out == e_iz)
    else $error("bad zero store");
  zero_reg_a: assert property (!pm &&
    hit == bmd_pkg::BMD_OP_STORE_ZERO |-> illegal && !byte_we)
    else $error("zero store taken");
endmodule : bmd_datapath_chk
bind bmd_datapath bmd_datapath_chk bmd_datapath_chk_inst (.*);

/* File: verif/tb_bmd_datapath.sv */
// self-checking bench for the bit manipulation datapath
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %0t: %h not %h", $time, a, e); end end
module tb_bmd_datapath;
  logic core_clk = 0, rstn = 0, op_valid = 0, operand_is_mem = 0, ld = 0;
  logic carry_in = 0, zero_in = 0, done, carry_we, carry_out, e;
  logic byte_we, byte_to_mem, reg_we, illegal;
  logic [2:0] bit_imm = 0;
  logic [7:0] field_mask = 0, source_register = 0, ld_val = 0, d;
  logic [7:0] source_operand, byte_out, reg_out;
  bmd_pkg::bmd_op_t op = bmd_pkg::BMD_OP_NONE;
  int n_fail = 0, tests_run = 0, cyc = 0;
  bmd_datapath bmd_datapath_inst (.*);
  bmd_mem_model bmd_mem_model_inst (.*);
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 3000) begin n_fail++; wrap_up(); end
  // one request at a falling edge; results read a cycle later
  task automatic run(bmd_pkg::bmd_op_t o, logic [2:0] b, logic im, c, z);
    @(negedge core_clk);
    op = o; bit_imm = b; operand_is_mem = im; carry_in = c; zero_in = z;
    op_valid = 1;
    @(negedge core_clk) op_valid = 0;
  endtask
  task automatic put(logic [7:0] v);
    @(negedge core_clk) begin ld = 1; ld_val = v; end
    @(negedge core_clk) ld = 0;
  endtask
  // carry logic and loads over all bit numbers and carry values
  task automatic t_carry;
    put(8'h5a);
    for (int o = 1; o < 6; o++) for (int i = 0; i < 16; i++) begin
      e = d[0];
      d = 8'h5a >> i[2:0];
      case (o) 1: e = i[3] | ~d[0]; 2: e = i[3] ^ d[0];
        3: e = i[3] ^ ~d[0]; 4: e = d[0]; default: e = ~d[0]; endcase
      run(bmd_pkg::bmd_op_t'(o[3:0]), i[2:0], i[0], i[3], 1'b0);
      `CHK({done, carry_we}, 2'b11)
      `CHK(carry_out, e)
    end
  endtask
  // bit stores into memory: only the chosen bit changes
  task automatic t_store;
    for (int o = 6; o < 10; o++) for (int i = 0; i < 8; i++) begin
      put(8'ha5);
      d = 8'ha5;
      d[i] = o == 6 ? i[0] : o == 7 ? ~i[0] : o == 8 ? i[1] : ~i[1];
      run(bmd_pkg::bmd_op_t'(o[3:0]), i[2:0], 1'b1, i[0], i[1]);
      `CHK(byte_out, d)
      @(negedge core_clk) `CHK(source_operand, d)
    end
  endtask
  // zero-flag stores to a register are refused
  task automatic t_refuse;
    run(bmd_pkg::BMD_OP_STORE_ZERO, 3'h2, 1'b0, 1'b0, 1'b1);
    `CHK({illegal, byte_we}, 2'b10)
    run(bmd_pkg::BMD_OP_STORE_INV_ZERO, 3'h5, 1'b0, 1'b0, 1'b1);
    `CHK({illegal, byte_we}, 2'b10)
  endtask
  // carry store to a register: written back, memory byte untouched
  task automatic t_reg_store;
    put(8'h3c);
    run(bmd_pkg::BMD_OP_STORE_CARRY, 3'h1, 1'b0, 1'b1, 1'b0);
    `CHK({done, byte_we, byte_to_mem}, 3'b110)
    `CHK(byte_out, 8'h3e)
    @(negedge core_clk) `CHK(source_operand, 8'h3c)
    run(bmd_pkg::BMD_OP_NONE, 3'h0, 1'b1, 1'b1, 1'b1);
    `CHK({illegal, carry_we, byte_we, reg_we}, 4'h8)
  endtask
  // field moves: extract aligns to bit 0, insert keeps outer bits
  task automatic t_field;
    put(8'hd6);
    field_mask = 8'h38;
    source_register = 8'hfd;
    run(bmd_pkg::BMD_OP_EXTRACT_FIELD, 3'h0, 1'b1, 1'b0, 1'b0);
    `CHK({reg_we, reg_out}, 9'h102)
    run(bmd_pkg::BMD_OP_INSERT_FIELD, 3'h0, 1'b1, 1'b0, 1'b0);
    `CHK({byte_we, byte_out}, 9'h1ee)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rstn = 1;
    t_carry();
    t_store();
    t_refuse();
    t_reg_store();
    t_field();
    wrap_up();
  end
endmodule : tb_bmd_datapath
